// ==== rtl/timer16_params.svh ====
// Register offsets, field positions and reset values of the 16-bit timer
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TMR_ADDR_W      4
`define OFS_CTRL_TWO    4'h0
`define OFS_CTRL_ONE    4'h1
`define OFS_STATUS      4'h2
`define OFS_CAP1_HI     4'h3
`define OFS_CAP1_LO     4'h4
`define OFS_CMP1_HI     4'h5
`define OFS_CMP1_LO     4'h6
`define OFS_CNT_HI      4'h7
`define OFS_CNT_LO      4'h8
`define OFS_ALT_HI      4'h9
`define OFS_ALT_LO      4'hA
`define OFS_CAP2_HI     4'hB
`define OFS_CAP2_LO     4'hC
`define OFS_CMP2_HI     4'hD
`define OFS_CMP2_LO     4'hE

// ----------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------
`define C1_CAP_IE       7
`define C1_CMP_IE       6
`define C1_OVF_IE       5
`define C1_FORCE_TWO    4
`define C1_FORCE_ONE    3
`define C1_LEVEL_TWO    2
`define C1_EDGE_ONE     1
`define C1_LEVEL_ONE    0

// ----------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------
`define C2_OUT_ONE_EN   7
`define C2_OUT_TWO_EN   6
`define C2_ONE_PULSE    5
`define C2_PWM          4
`define C2_EDGE_TWO     1

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SR_CAP_ONE      7
`define SR_CMP_ONE      6
`define SR_OVF          5
`define SR_CAP_TWO      4
`define SR_CMP_TWO      3

// ----------------------------------------------------------------
// Reset values and counter top
// ----------------------------------------------------------------
`define CTRL_ONE_RST    8'h00
`define CTRL_TWO_RST    8'h00
`define STATUS_RST      8'h00
`define CNT_RST         16'hFFFC
`define CNT_TOP         16'hFFFF
`define CMP_RST         16'hFFFF
`define CAP_RST         16'h0000

`endif

// ==== rtl/timer16_pkg.sv ====
// Types shared by the 16-bit timer files
`include "timer16_params.svh"

package timer16_pkg;

    typedef struct packed {
        logic [`TMR_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr;
        logic                   rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        mode_normal,
        mode_one_pulse,
        mode_pwm
    } timer_mode_t;

endpackage

// ==== rtl/capture_sync.sv ====
// Pin synchroniser with settled-level edge detection
`timescale 1ns/1ps

module capture_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Pin and edge choice
    input  wire logic pin_in,
    input  wire logic rising_sel,
    // Detected edge
    output logic      edge_pulse
);

    logic       s1_r;
    logic       s2_r;
    logic       s3_r;
    logic       level_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Level moves only when the last two stages agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_r    <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            edge_pulse <= 1'b0;
            if (s2_r == s3_r && s2_r != level_r) begin
                level_r    <= s2_r;
                edge_pulse <= (s2_r == rising_sel);
            end
        end
    end

endmodule

// ==== rtl/timer16_control_reg1.sv ====
// 16-bit capture/compare timer with its first control register
`timescale 1ns/1ps
`include "timer16_params.svh"

module timer16_control_reg1 #(
    parameter int PRESCALE = 4
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // Register port
    input  timer16_pkg::reg_req_t     reg_req,
    output logic [7:0]                rd_data,
    // Capture pins
    input  wire logic                 capture_pin_one,
    input  wire logic                 capture_pin_two,
    // Compare pins
    output logic                      compare_pin_one,
    output logic                      compare_pin_two,
    // Interrupt request
    output logic                      timer_irq
);
    import timer16_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]             timer_control_one_r;
    logic [7:0]             timer_control_two_r;
    logic [7:0]             timer_status_r;
    logic [7:0]             status_set;
    logic [7:0]             status_clr;
    logic [15:0]            cnt_r;
    logic [15:0]            alt_cnt_r;
    logic [15:0]            cap_one_r;
    logic [15:0]            cap_two_r;
    logic [15:0]            compare_value_one_r;
    logic [15:0]            compare_value_two_r;
    logic [$clog2(PRESCALE+1)-1:0] div_r;
    logic                   tick;
    logic [1:0]             cap_evt;
    logic [1:0]             edge_sel;
    logic [1:0]             cap_pins;
    logic                   match_one;
    logic                   match_two;
    logic                   overflow_evt;
    logic [7:0]             rd_mux;
    logic                   wr_cnt;
    timer_mode_t            mode;

    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_output_two;
    logic force_output_one;
    logic output_level_two;
    logic capture_one_edge_select;
    logic output_level_one;
    logic compare_out_one_enable;
    logic compare_out_two_enable;

    assign capture_irq_enable      = timer_control_one_r[`C1_CAP_IE];
    assign compare_irq_enable      = timer_control_one_r[`C1_CMP_IE];
    assign overflow_irq_enable     = timer_control_one_r[`C1_OVF_IE];
    assign force_output_two        = timer_control_one_r[`C1_FORCE_TWO];
    assign force_output_one        = timer_control_one_r[`C1_FORCE_ONE];
    assign output_level_two        = timer_control_one_r[`C1_LEVEL_TWO];
    assign capture_one_edge_select = timer_control_one_r[`C1_EDGE_ONE];
    assign output_level_one        = timer_control_one_r[`C1_LEVEL_ONE];
    assign compare_out_one_enable  = timer_control_two_r[`C2_OUT_ONE_EN];
    assign compare_out_two_enable  = timer_control_two_r[`C2_OUT_TWO_EN];

    // PWM wins when both mode bits are set
    always_comb begin
        if (timer_control_two_r[`C2_PWM]) begin
            mode = mode_pwm;
        end else if (timer_control_two_r[`C2_ONE_PULSE]) begin
            mode = mode_one_pulse;
        end else begin
            mode = mode_normal;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_control_one_r <= `CTRL_ONE_RST;
        end else if (reg_req.wr && reg_req.addr == `OFS_CTRL_ONE) begin
            timer_control_one_r <= reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_control_two_r <= `CTRL_TWO_RST;
        end else if (reg_req.wr && reg_req.addr == `OFS_CTRL_TWO) begin
            timer_control_two_r <= reg_req.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Capture inputs
    // ----------------------------------------------------------------
    assign cap_pins = {capture_pin_two, capture_pin_one};
    assign edge_sel = {timer_control_two_r[`C2_EDGE_TWO], capture_one_edge_select};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cap
            capture_sync u_sync (
                .ref_clk    (ref_clk),
                .reset      (reset),
                .pin_in     (cap_pins[gi]),
                .rising_sel (edge_sel[gi]),
                .edge_pulse (cap_evt[gi])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cap_one_r <= `CAP_RST;
            cap_two_r <= `CAP_RST;
        end else begin
            if (cap_evt[0]) begin
                cap_one_r <= cnt_r;
            end
            if (cap_evt[1]) begin
                cap_two_r <= cnt_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    assign tick         = (div_r == PRESCALE[$bits(div_r)-1:0] - 1'b1);
    assign wr_cnt       = reg_req.wr && (reg_req.addr == `OFS_CNT_HI ||
                                         reg_req.addr == `OFS_CNT_LO);
    assign match_one    = tick && cnt_r == compare_value_one_r;
    assign match_two    = tick && cnt_r == compare_value_two_r;
    assign overflow_evt = tick && cnt_r == `CNT_TOP;

    always_ff @(posedge ref_clk) begin
        if (reset || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // Writing either counter byte restarts the main counter
    always_ff @(posedge ref_clk) begin
        if (reset || wr_cnt) begin
            cnt_r <= `CNT_RST;
        end else if (mode == mode_one_pulse && cap_evt[0]) begin
            cnt_r <= `CNT_RST;
        end else if (mode == mode_pwm && match_two) begin
            cnt_r <= `CNT_RST;
        end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Free-running count, untouched by writes and modes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alt_cnt_r <= `CNT_RST;
        end else if (tick) begin
            alt_cnt_r <= alt_cnt_r + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Compare registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            compare_value_one_r <= `CMP_RST;
            compare_value_two_r <= `CMP_RST;
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                `OFS_CMP1_HI: compare_value_one_r[15:8] <= reg_req.wdata;
                `OFS_CMP1_LO: compare_value_one_r[7:0]  <= reg_req.wdata;
                `OFS_CMP2_HI: compare_value_two_r[15:8] <= reg_req.wdata;
                `OFS_CMP2_LO: compare_value_two_r[7:0]  <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status flags: write one to clear, a new event wins
    // ----------------------------------------------------------------
    always_comb begin
        status_set                = '0;
        status_set[`SR_CAP_ONE]   = cap_evt[0];
        status_set[`SR_CAP_TWO]   = cap_evt[1];
        status_set[`SR_CMP_ONE]   = match_one;
        status_set[`SR_CMP_TWO]   = match_two;
        status_set[`SR_OVF]       = overflow_evt;
        status_clr                = '0;
        if (reg_req.wr && reg_req.addr == `OFS_STATUS) begin
            status_clr = reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_status_r <= `STATUS_RST;
        end else begin
            timer_status_r <= status_set | (timer_status_r & ~status_clr);
        end
    end

    // ----------------------------------------------------------------
    // Compare outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            compare_pin_one <= 1'b0;
        end else begin
            unique case (mode)
                mode_normal: begin
                    if (compare_out_one_enable && (force_output_one || match_one)) begin
                        compare_pin_one <= output_level_one;
                    end
                end
                mode_pwm: begin
                    if (match_two) begin
                        compare_pin_one <= output_level_one;
                    end else if (match_one) begin
                        compare_pin_one <= output_level_two;
                    end
                end
                mode_one_pulse: begin
                    if (cap_evt[0]) begin
                        compare_pin_one <= output_level_one;
                    end else if (match_one) begin
                        compare_pin_one <= output_level_two;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            compare_pin_two <= 1'b0;
        end else if (mode == mode_normal && compare_out_two_enable &&
                     (force_output_two || match_two)) begin
            compare_pin_two <= output_level_two;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= (capture_irq_enable &&
                          (timer_status_r[`SR_CAP_ONE] || timer_status_r[`SR_CAP_TWO])) ||
                         (compare_irq_enable &&
                          (timer_status_r[`SR_CMP_ONE] || timer_status_r[`SR_CMP_TWO])) ||
                         (overflow_irq_enable && timer_status_r[`SR_OVF]);
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb begin
        unique case (reg_req.addr)
            `OFS_CTRL_TWO: rd_mux = timer_control_two_r;
            `OFS_CTRL_ONE: rd_mux = timer_control_one_r;
            `OFS_STATUS:   rd_mux = timer_status_r;
            `OFS_CAP1_HI:  rd_mux = cap_one_r[15:8];
            `OFS_CAP1_LO:  rd_mux = cap_one_r[7:0];
            `OFS_CMP1_HI:  rd_mux = compare_value_one_r[15:8];
            `OFS_CMP1_LO:  rd_mux = compare_value_one_r[7:0];
            `OFS_CNT_HI:   rd_mux = cnt_r[15:8];
            `OFS_CNT_LO:   rd_mux = cnt_r[7:0];
            `OFS_ALT_HI:   rd_mux = alt_cnt_r[15:8];
            `OFS_ALT_LO:   rd_mux = alt_cnt_r[7:0];
            `OFS_CAP2_HI:  rd_mux = cap_two_r[15:8];
            `OFS_CAP2_LO:  rd_mux = cap_two_r[7:0];
            `OFS_CMP2_HI:  rd_mux = compare_value_two_r[15:8];
            `OFS_CMP2_LO:  rd_mux = compare_value_two_r[7:0];
            default:       rd_mux = 8'h00;
        endcase
    end

    // Data stand for one cycle only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= 8'h00;
        end else if (reg_req.rd) begin
            rd_data <= rd_mux;
        end else begin
            rd_data <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_ctrl_one_reset:
        assert property ($fell(reset) |-> timer_control_one_r == `CTRL_ONE_RST)
        else $error("control one not zero after reset");
    a_ctrl_one_readback:
        assert property (reg_req.wr && reg_req.addr == `OFS_CTRL_ONE ##1
                         reg_req.rd && reg_req.addr == `OFS_CTRL_ONE
                         |=> rd_data == $past(reg_req.wdata, 2))
        else $error("control one readback mismatch");
    a_capture_holds_count:
        assert property (cap_evt[0] |=> cap_one_r == $past(cnt_r))
        else $error("capture one did not hold the count");
    a_irq_capture:
        assert property (capture_irq_enable && timer_status_r[`SR_CAP_TWO] |=> timer_irq)
        else $error("capture interrupt missing");
    a_irq_compare:
        assert property (compare_irq_enable && timer_status_r[`SR_CMP_ONE] |=> timer_irq)
        else $error("compare interrupt missing");
    a_irq_overflow:
        assert property (overflow_irq_enable && timer_status_r[`SR_OVF] |=> timer_irq)
        else $error("overflow interrupt missing");
    a_irq_inhibit:
        assert property (!capture_irq_enable && !compare_irq_enable && !overflow_irq_enable
                         |=> !timer_irq)
        else $error("interrupt raised while all enables off");
    a_force_pin_two:
        assert property (mode == mode_normal && force_output_two && compare_out_two_enable
                         |=> compare_pin_two == $past(output_level_two))
        else $error("forced level two not on pin two");
    a_force_pin_one:
        assert property (mode == mode_normal && force_output_one && compare_out_one_enable
                         |=> compare_pin_one == $past(output_level_one))
        else $error("forced level one not on pin one");
    a_match_pin_two:
        assert property (mode == mode_normal && match_two && compare_out_two_enable
                         |=> compare_pin_two == $past(output_level_two))
        else $error("match two level not on pin two");
    a_pwm_level_two:
        assert property (mode == mode_pwm && match_one && !match_two
                         |=> compare_pin_one == $past(output_level_two))
        else $error("pwm level two not on pin one");
    a_edge_sets_flag:
        assert property (cap_evt[0] |=> timer_status_r[`SR_CAP_ONE])
        else $error("capture one flag not set");
    a_match_pin_one:
        assert property (mode == mode_normal && match_one && compare_out_one_enable
                         |=> compare_pin_one == $past(output_level_one))
        else $error("match one level not on pin one");

    c_capture_irq: cover property (cap_evt[0] && capture_irq_enable ##2 timer_irq);
    c_match_pin:   cover property (match_one && compare_out_one_enable);
    c_pwm_period:  cover property (mode == mode_pwm && match_two);
    c_overflow:    cover property (overflow_evt);

endmodule

// ==== verif/capture_source.sv ====
// Pin-side model driving the two capture inputs of the timer
`timescale 1ns/1ps

module capture_source (
    // Clock
    input  wire logic ref_clk,
    // Requested pin levels
    input  wire logic want_one,
    input  wire logic want_two,
    // Capture pins
    output logic      capture_pin_one,
    output logic      capture_pin_two
);
    // Known low level from time zero
    initial begin
        capture_pin_one = 1'b0;
        capture_pin_two = 1'b0;
    end

    // Pins change just after the edge, unrelated to the timer's sampling
    always @(posedge ref_clk) begin
        capture_pin_one <= #7 want_one;
        capture_pin_two <= #7 want_two;
    end
endmodule

// ==== verif/tb_timer16_control_reg1.sv ====
// Self-checking testbench for control register one of the 16-bit timer
`timescale 1ns/1ps
`include "timer16_params.svh"

module tb_timer16_control_reg1;
    import timer16_pkg::*;

    logic       ref_clk;
    logic       reset;
    reg_req_t   reg_req;
    logic [7:0] rd_data;
    logic       cap_one;
    logic       cap_two;
    logic       want_one;
    logic       want_two;
    logic       compare_pin_one;
    logic       compare_pin_two;
    logic       timer_irq;
    logic [7:0] rv;
    int         err_count;
    int         checked;

    timer16_control_reg1 #(.PRESCALE(1)) timer16_control_reg1_i (
        .ref_clk(ref_clk), .reset(reset), .reg_req(reg_req), .rd_data(rd_data),
        .capture_pin_one(cap_one), .capture_pin_two(cap_two),
        .compare_pin_one(compare_pin_one), .compare_pin_two(compare_pin_two),
        .timer_irq(timer_irq));

    capture_source capture_source_i (
        .ref_clk(ref_clk), .want_one(want_one), .want_two(want_two),
        .capture_pin_one(cap_one), .capture_pin_two(cap_two));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
        d = rd_data;
    endtask

    // Write then read back with no gap between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
        q = rd_data;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic probe(input int sel);
        case (sel)
            0: return compare_pin_one;
            1: return compare_pin_two;
            default: return timer_irq;
        endcase
    endfunction

    // Bounded wait on a pin or the interrupt, then one compare
    task automatic wait_for(input int sel, input logic v);
        int n;
        #1;
        n = 0;
        while (probe(sel) !== v && n < 1000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({7'h00, probe(sel)}, {7'h00, v});
        if (n >= 1000) begin
            end_of_test();
        end
    endtask

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        err_count = 0;
        checked = 0;
        reset = 1'b1;
        reg_req = '0;
        want_one = 1'b0;
        want_two = 1'b0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`OFS_CTRL_ONE, rv);
        check(rv, `CTRL_ONE_RST);
        wr_rd(`OFS_CTRL_ONE, 8'hA5, rv);
        check(rv, 8'hA5);
        wr_rd(`OFS_CTRL_ONE, 8'h5A, rv);
        check(rv, 8'h5A);
        rd(4'hF, rv);
        check(rv, 8'h00);
        // Overflow enable
        wr(`OFS_CTRL_ONE, 8'h00);
        rd(`OFS_STATUS, rv);
        check(rv & 8'h20, 8'h20);
        check({7'h00, timer_irq}, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h20);
        idle(2);
        check({7'h00, timer_irq}, 8'h01);
        wr(`OFS_STATUS, 8'hFF);
        idle(2);
        check({7'h00, timer_irq}, 8'h00);
        // Forced outputs
        wr(`OFS_CTRL_TWO, 8'hC0);
        wr(`OFS_CTRL_ONE, 8'h09);
        wait_for(0, 1'b1);
        check({7'h00, compare_pin_two}, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h14);
        wait_for(1, 1'b1);
        check({7'h00, compare_pin_one}, 8'h01);
        wr(`OFS_CTRL_ONE, 8'h18);
        wait_for(0, 1'b0);
        wait_for(1, 1'b0);
        // Compare matches, counter reload
        wr(`OFS_CTRL_ONE, 8'h45);
        wr(`OFS_CMP1_HI, 8'h01);
        wr(`OFS_CMP1_LO, 8'h00);
        wr(`OFS_CNT_LO, 8'h00);
        rd(`OFS_CNT_HI, rv);
        check(rv, 8'hFF);
        wait_for(1, 1'b1);
        wait_for(0, 1'b1);
        rd(`OFS_STATUS, rv);
        check(rv & 8'h48, 8'h48);
        check({7'h00, timer_irq}, 8'h01);
        wr(`OFS_STATUS, 8'hFF);
        idle(2);
        check({7'h00, timer_irq}, 8'h00);
        // Capture edge choice
        wr(`OFS_CTRL_ONE, 8'h82);
        @(posedge ref_clk);
        want_one <= 1'b1;
        wait_for(2, 1'b1);
        wr(`OFS_STATUS, 8'hFF);
        @(posedge ref_clk);
        want_one <= 1'b0;
        idle(10);
        rd(`OFS_STATUS, rv);
        check(rv & 8'h80, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h80);
        @(posedge ref_clk);
        want_one <= 1'b1;
        idle(10);
        check({7'h00, timer_irq}, 8'h00);
        @(posedge ref_clk);
        want_one <= 1'b0;
        wait_for(2, 1'b1);
        wr(`OFS_STATUS, 8'hFF);
        wr(`OFS_CTRL_TWO, 8'hC2);
        @(posedge ref_clk);
        want_two <= 1'b1;
        wait_for(2, 1'b1);
        rd(`OFS_STATUS, rv);
        check(rv & 8'h10, 8'h10);
        // Pulse width modulation
        wr(`OFS_CTRL_ONE, 8'h04);
        wr(`OFS_CMP2_HI, 8'h02);
        wr(`OFS_CMP2_LO, 8'h00);
        wr(`OFS_CTRL_TWO, 8'h90);
        wr(`OFS_CNT_LO, 8'h00);
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
        end_of_test();
    end
endmodule
